// ---- rtl/asm_defs.svh ----
`ifndef ASM_DEFS_SVH
`define ASM_DEFS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define ASM_IDX_STATUS      8'h01
`define ASM_IDX_MODE        8'h02
`define ASM_IDX_CLOCK       8'h03

// ----------------------------------------
// reset values
// ----------------------------------------
`define ASM_STATUS_RESET    16'h0500
`define ASM_MODE_RESET      16'h0510
`define ASM_CHAN_EN_RESET   6'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define ASM_ST_LOCK         15
`define ASM_ST_RESYNC       14
`define ASM_ST_REGMAP       13
`define ASM_ST_CRCERR       12
`define ASM_CLK_EN_LSB      8
`define ASM_CLK_EN_MSB      13
`define ASM_MODE_RSVD_MASK  16'h3fff

// ----------------------------------------
// ready pin source codes
// ----------------------------------------
`define ASM_SRC_LAGGING     2'b00
`define ASM_SRC_ANY         2'b01

// ----------------------------------------
// timing
// ----------------------------------------
`define ASM_CLK_PERIOD_NS   10
`define ASM_TIMEOUT_NS      1000000
`define ASM_PULSE_NS        80

`endif

// ---- rtl/asm_pkg.sv ----
package asm_pkg;

	typedef struct packed {
		logic       lock;
		logic       resync;
		logic       regMapChanged;
		logic       rxCrcError;
		logic [5:0] newSample;
	} asm_events_t;

	typedef struct packed {
		logic [1:0] rsvdHi;
		logic       regCrcEn;
		logic       rxCrcEn;
		logic       crcAnsi;
		logic       resetMark;
		logic [1:0] sampleWordSize;
		logic [2:0] rsvdLo;
		logic       timeoutEn;
		logic [1:0] readyPinSource;
		logic       readyPinIdleFloat;
		logic       readyPinPulseStyle;
	} asm_mode_t;

	typedef enum logic [3:0] {
		RDY_IDLE  = 4'b0001,
		RDY_HOLD  = 4'b0010,
		RDY_PULSE = 4'b0100,
		RDY_WAIT  = 4'b1000
	} asm_ready_state_t;

endpackage

// ---- rtl/asm_regs.sv ----
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "asm_defs.svh"
// Notes on behaviour
// (RULE1) status bit 15 shows serial interface lock, unlocked after reset
// (RULE2) status bit 14 is set on every converter resynchronization
// (RULE3) status bit 13 is set when the register map checksum changes
// (RULE4) status bit 12 is set on an incoming serial checksum error
// (RULE5) status bit 11 shows polynomial, 0 CCITT, 1 ANSI, reset 0
// (RULE6) status bit 10 reads 1 after reset until cleared
// (RULE7) status bits 9:8 show active word length, reset 01b
// (RULE8) status bits 5:0 flag new results for channels 5 to 0
// (RULE9) status bits 7:6 always read zero
// (RULE10) mode bit 13 enables register map checksum monitoring, off at reset
// (RULE11) mode bit 12 enables incoming serial checksum checking, off at reset
// (RULE12) mode bit 11 selects checksum polynomial for both checks
// (RULE13) mode bit 10 resets to 1; host writing 0 clears status bit 10
// (RULE14) mode bits 9:8 select word length, 24 bits by default
// (RULE15) host writes zero to reserved mode bits 7:5
// (RULE16) mode bit 4 enables the serial timeout, on at reset
// (RULE17) mode bits 3:2 select ready pin source: lagging, any, leading
// (RULE18) mode bit 1: idle ready pin driven high or floating
// (RULE19) mode bit 0: ready held low or given a fixed low pulse
// (RULE20) status register index 01h, 16 bits, read-only, reset 0500h
// (RULE21) mode register index 02h, 16 bits, read-write, reset 0510h
// (RULE22) channels count as enabled by clock register bits 13:8
// (RULE23) writes to the status register are ignored
// (RULE24) status mirrors of mode fields change with the mode write

module asm_regs
	import asm_pkg::*;
#(
	parameter int TIMEOUT_CYC = `ASM_TIMEOUT_NS / `ASM_CLK_PERIOD_NS,
	parameter int TMO_W       = $clog2(TIMEOUT_CYC + 1)
)
(
	input  wire logic        clk,           // system clock, 100 MHz
	input  wire logic        reset,         // async reset, active high
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction, 1 = write
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error, unmapped address
	input  wire asm_events_t events,        // converter events, same clock
	input  wire logic        serialClk,     // serial link clock pin
	input  wire logic        serialSelN,    // serial frame select pin, low active
	output asm_mode_t        modeOut,       // operating mode fields
	output logic      [5:0]  chanEnable,    // channel conversion on
	output logic             frameTimeout,  // one-cycle pulse, serial timeout
	output logic             readyPinOut,   // ready pin level
	output logic             readyPinOe     // ready pin driven when high
);

	// ----------------------------------------
	// constants
	// ----------------------------------------
	localparam int PULSE_CYC_I = (`ASM_PULSE_NS + `ASM_CLK_PERIOD_NS - 1) / `ASM_CLK_PERIOD_NS;
	localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYC_I - 1);
	localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);
	localparam logic [7:0] ADDR_STATUS = 8'(`ASM_IDX_STATUS * 8'd4);
	localparam logic [7:0] ADDR_MODE   = 8'(`ASM_IDX_MODE * 8'd4);
	localparam logic [7:0] ADDR_CLOCK  = 8'(`ASM_IDX_CLOCK * 8'd4);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		asm_mode_t        mode;
		logic [5:0]       chanEn;
		logic             resyncFlag;
		logic             regMapFlag;
		logic             crcErrFlag;
		logic             resetFlag;
		logic [5:0]       newFlags;
		logic             leadLatch;
		asm_ready_state_t rdyState;
		logic [3:0]       pulseCnt;
		logic             pinOut;
		logic             pinOe;
		logic [1:0]       sclkSync;
		logic [1:0]       selSync;
		logic             sclkLast;
		logic [TMO_W-1:0] tmoCnt;
		logic             tmoFired;
		logic             tmoPulse;
	} asm_state_t;

	localparam asm_state_t RESET_STATE = '{
		prdata:     32'h0000_0000,
		pready:     1'b0,
		pslverr:    1'b0,
		mode:       asm_mode_t'(`ASM_MODE_RESET),
		chanEn:     `ASM_CHAN_EN_RESET,
		resyncFlag: 1'b0,
		regMapFlag: 1'b0,
		crcErrFlag: 1'b0,
		resetFlag:  1'b1,
		newFlags:   6'h00,
		leadLatch:  1'b0,
		rdyState:   RDY_IDLE,
		pulseCnt:   4'h0,
		pinOut:     1'b1,
		pinOe:      1'b1,
		sclkSync:   2'b00,
		selSync:    2'b11,
		sclkLast:   1'b0,
		tmoCnt:     '0,
		tmoFired:   1'b0,
		tmoPulse:   1'b0
	};

	asm_state_t s;
	asm_state_t next_s;

	// ----------------------------------------
	// combinational helpers
	// ----------------------------------------
	logic        access;
	logic        commit;
	logic        hitStatus;
	logic        hitMode;
	logic        hitClock;
	logic [15:0] statusValue;
	logic [15:0] readValue;
	logic [15:0] clearMask;
	logic [5:0]  enNew;
	logic        allDone;
	logic        anyNew;
	logic        readyCond;
	logic        sclkEdge;
	logic        frameOpen;
	asm_mode_t   wrMode;

	assign access    = psel & penable;
	assign commit    = access & s.pready;
	assign hitStatus = (paddr == ADDR_STATUS);
	assign hitMode   = (paddr == ADDR_MODE);
	assign hitClock  = (paddr == ADDR_CLOCK);
	assign wrMode    = asm_mode_t'(pwdata[15:0] & `ASM_MODE_RSVD_MASK);

	// mirrors read the live mode fields, so they follow a mode write at once
	assign statusValue = {
		events.lock,               // see (RULE1)
		s.resyncFlag,              // see (RULE2)
		s.regMapFlag,              // see (RULE3)
		s.crcErrFlag,              // see (RULE4)
		s.mode.crcAnsi,            // see (RULE5) see (RULE24)
		s.resetFlag,               // see (RULE6)
		s.mode.sampleWordSize,     // see (RULE7) see (RULE24)
		2'b00,                     // see (RULE9)
		s.newFlags                 // see (RULE8)
	};

	always_comb
	begin
		if (hitStatus)
		begin
			readValue = statusValue;        // see (RULE20)
		end
		else if (hitMode)
		begin
			readValue = 16'(s.mode);        // see (RULE21)
		end
		else if (hitClock)
		begin
			readValue = {2'b00, s.chanEn, 8'h00};
		end
		else
		begin
			readValue = 16'h0000;
		end
	end

	// only the bits the host actually saw are cleared by a status read
	always_comb
	begin
		clearMask = 16'h0000;
		if (commit && !pwrite && hitStatus)
		begin
			clearMask = s.prdata[15:0];
		end
	end

	assign enNew   = s.newFlags & s.chanEn;                            // see (RULE22)
	assign allDone = (|s.chanEn) & (&(s.newFlags | ~s.chanEn));
	assign anyNew  = |enNew;

	always_comb
	begin
		if (s.mode.readyPinSource == `ASM_SRC_LAGGING)
		begin
			readyCond = allDone;                                       // see (RULE17)
		end
		else if (s.mode.readyPinSource == `ASM_SRC_ANY)
		begin
			readyCond = anyNew;                                        // see (RULE17)
		end
		else
		begin
			readyCond = s.leadLatch;                                   // see (RULE17)
		end
	end

	assign sclkEdge  = s.sclkSync[1] ^ s.sclkLast;
	assign frameOpen = ~s.selSync[1];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_s = s;

		// apb: one wait state, answer loaded then committed on the ready edge
		if (access && !s.pready)
		begin
			next_s.pready  = 1'b1;
			next_s.pslverr = ~(hitStatus | hitMode | hitClock);
			next_s.prdata  = {16'h0000, readValue};
		end
		else
		begin
			next_s.pready  = 1'b0;
			next_s.pslverr = 1'b0;
		end

		if (commit && pwrite)
		begin
			if (hitMode)
			begin
				next_s.mode = wrMode;                                  // see (RULE21) see (RULE15)
				if (!wrMode.resetMark)
				begin
					next_s.resetFlag = 1'b0;                           // see (RULE13)
				end
			end
			else if (hitClock)
			begin
				next_s.chanEn = pwdata[`ASM_CLK_EN_MSB:`ASM_CLK_EN_LSB]; // see (RULE22)
			end
			// a status write falls through and changes nothing, see (RULE23)
		end

		// sticky flags: a new event wins over a clear in the same cycle
		next_s.resyncFlag = (s.resyncFlag & ~clearMask[`ASM_ST_RESYNC])
			| events.resync;                                           // see (RULE2)
		next_s.regMapFlag = (s.regMapFlag & ~clearMask[`ASM_ST_REGMAP])
			| (events.regMapChanged & s.mode.regCrcEn);                // see (RULE3) see (RULE10)
		next_s.crcErrFlag = (s.crcErrFlag & ~clearMask[`ASM_ST_CRCERR])
			| (events.rxCrcError & s.mode.rxCrcEn);                    // see (RULE4) see (RULE11)
		next_s.newFlags   = (s.newFlags & ~clearMask[5:0])
			| events.newSample;                                        // see (RULE8)

		// leading source: first enabled channel raises it, full set drops it
		if (allDone)
		begin
			next_s.leadLatch = 1'b0;
		end
		else if (|(events.newSample & s.chanEn))
		begin
			next_s.leadLatch = 1'b1;
		end
		else if (!anyNew)
		begin
			next_s.leadLatch = 1'b0;
		end

		// ready pin sequencer
		case (s.rdyState)
			RDY_IDLE:
			begin
				if (readyCond)
				begin
					if (s.mode.readyPinPulseStyle)
					begin
						next_s.rdyState = RDY_PULSE;                   // see (RULE19)
						next_s.pulseCnt = PULSE_LAST;
					end
					else
					begin
						next_s.rdyState = RDY_HOLD;                    // see (RULE19)
					end
				end
			end
			RDY_HOLD:
			begin
				if (!readyCond)
				begin
					next_s.rdyState = RDY_IDLE;
				end
			end
			RDY_PULSE:
			begin
				if (s.pulseCnt == 4'h0)
				begin
					next_s.rdyState = RDY_WAIT;
				end
				else
				begin
					next_s.pulseCnt = s.pulseCnt - 4'h1;
				end
			end
			RDY_WAIT:
			begin
				if (!readyCond)
				begin
					next_s.rdyState = RDY_IDLE;
				end
			end
			default:
			begin
				next_s.rdyState = RDY_IDLE;
			end
		endcase

		// pin follows the next state so it leaves a flip-flop directly
		if (next_s.rdyState == RDY_HOLD || next_s.rdyState == RDY_PULSE)
		begin
			next_s.pinOut = 1'b0;
			next_s.pinOe  = 1'b1;
		end
		else
		begin
			next_s.pinOut = 1'b1;
			next_s.pinOe  = ~s.mode.readyPinIdleFloat;                 // see (RULE18)
		end

		// serial pins: two flip-flops before anything reads them
		next_s.sclkSync = {s.sclkSync[0], serialClk};
		next_s.selSync  = {s.selSync[0], serialSelN};
		next_s.sclkLast = s.sclkSync[1];

		// timeout: link clock may stop between frames, so count only inside one
		next_s.tmoPulse = 1'b0;
		if (!frameOpen || sclkEdge || !s.mode.timeoutEn)
		begin
			next_s.tmoCnt   = '0;
			next_s.tmoFired = 1'b0;
		end
		else if (!s.tmoFired)
		begin
			if (s.tmoCnt == TMO_LAST)
			begin
				next_s.tmoFired = 1'b1;                                // see (RULE16)
				next_s.tmoPulse = 1'b1;
			end
			else
			begin
				next_s.tmoCnt = s.tmoCnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s <= RESET_STATE;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata       = s.prdata;
	assign pready       = s.pready;
	assign pslverr      = s.pslverr;
	assign modeOut      = s.mode;           // see (RULE12) see (RULE14)
	assign chanEnable   = s.chanEn;
	assign frameTimeout = s.tmoPulse;
	assign readyPinOut  = s.pinOut;
	assign readyPinOe   = s.pinOe;

endmodule

// ---- tb/asm_host_link.sv ----
`timescale 1ns/10ps
module asm_host_link
(
	input  wire logic frameOn,   // host holds a frame open
	input  wire logic stall,     // host stops the clock mid-frame
	output logic      serialClk, // link clock, idle low
	output logic      serialSelN // frame select, low active
);
	// ----------------------------------------
	// link clock, 160 ns, phase free of clk
	// ----------------------------------------
	initial
	begin
		serialClk = 1'b0;
		#3;
		forever
		begin
			#80;
			serialClk <= frameOn && !stall ? ~serialClk : 1'b0;
		end
	end
	assign serialSelN = ~frameOn;
endmodule

// ---- tb/asm_regs_properties.sv ----
`timescale 1ns/10ps
module asm_regs_props
	import asm_pkg::*;
#(
	parameter int TIMEOUT_CYC = 20 // idle cycles to timeout
)
(
	input wire logic        clk,          // clock
	input wire logic        reset,        // async reset
	input wire logic        psel,         // apb select
	input wire logic        penable,      // apb enable
	input wire logic        pwrite,       // apb direction
	input wire logic [7:0]  paddr,        // apb address
	input wire logic [31:0] pwdata,       // apb write data
	input wire logic [31:0] prdata,       // apb read data
	input wire logic        pready,       // apb ready
	input wire logic        pslverr,      // apb error
	input wire asm_mode_t   modeOut,      // mode fields
	input wire logic        frameTimeout, // timeout pulse
	input wire logic        readyPinOut,  // ready pin level
	input wire logic        readyPinOe    // ready pin enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	logic rdSt;
	logic hit;
	assign rdSt = pready && !pwrite && paddr == 8'h04;
	assign hit  = paddr inside {8'h04, 8'h08, 8'h0c};

	a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready ##1 !pready)
		else $error("apb answer timing wrong");
	a_unmapped_err: assert property (pready |-> pslverr == !hit)
		else $error("apb error flag wrong");
	a_unmapped_zero: assert property (pready && !hit |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	a_status_rsvd: assert property (rdSt |-> prdata[7:6] == 2'b00 && prdata[31:16] == 16'h0)
		else $error("status reserved bits set");
	a_status_mirror: assert property (rdSt |->
		{prdata[11], prdata[9:8]} == {modeOut.crcAnsi, modeOut.sampleWordSize})
		else $error("status mirror differs from mode");
	a_mode_write: assert property (pready && pwrite && paddr == 8'h08 |=>
		modeOut == ($past(pwdata[15:0]) & 16'h3fff))
		else $error("mode write not applied");
	a_mode_read: assert property (pready && !pwrite && paddr == 8'h08 |-> prdata == {16'h0, modeOut})
		else $error("mode read differs");
	a_low_driven: assert property (!readyPinOut |-> readyPinOe)
		else $error("ready pin low but floating");
	a_pulse_len: assert property ($fell(readyPinOut) && modeOut.readyPinPulseStyle |->
		!readyPinOut[*8] ##1 readyPinOut)
		else $error("ready pulse length wrong");
	a_timeout_off: assert property (!modeOut.timeoutEn && !$past(modeOut.timeoutEn) |-> !frameTimeout)
		else $error("timeout while disabled");

	c_mode_write: cover property (pready && pwrite && paddr == 8'h08);
	c_ready_pulse: cover property ($fell(readyPinOut) && modeOut.readyPinPulseStyle);
	c_timeout: cover property (frameTimeout);
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb
	import asm_pkg::*;
;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	asm_events_t ev;
	asm_mode_t   modeOut;
	logic        frameOn, stall, serialClk, serialSelN, frameTimeout, readyPinOut, readyPinOe;
	logic [5:0]  chanEn;
	int          n_errors, compares;
	int          timeoutCount = 0;

	asm_regs #(.TIMEOUT_CYC(20)) u_asm_regs (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.events(ev), .serialClk(serialClk), .serialSelN(serialSelN), .modeOut(modeOut), .chanEnable(chanEn),
		.frameTimeout(frameTimeout), .readyPinOut(readyPinOut), .readyPinOe(readyPinOe));
	asm_host_link u_asm_host_link (.frameOn(frameOn), .stall(stall), .serialClk(serialClk),
		.serialSelN(serialSelN));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (frameTimeout === 1'b1) timeoutCount <= timeoutCount + 1;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ----------------------------------------
	// apb master: pready, data and error taken at the same rising edge
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			n_errors++;
			complete_run();
		end
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, q);
	endtask

	task automatic pulse(input logic [9:0] p);
		@(posedge clk);
		ev <= p;
		@(posedge clk);
		ev <= {p[9], 9'h0};
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	initial
	begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, frameOn, stall} = '0;
		ev = '0;
		{n_errors, compares} = '0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd("status", 8'h04, 32'h0500);
		rd("mode", 8'h08, 32'h0510);
		rd("clock", 8'h0c, 32'h3f00);
		apb(1'b1, 8'h04, 32'hffff);
		rd("status kept", 8'h04, 32'h0500);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		$display("test map done");
		apb(1'b1, 8'h08, 32'h3b0f);
		rd("mode", 8'h08, 32'h3b0f);
		rd("status mirror", 8'h04, 32'h0b00);
		pulse(10'h3ff);
		rd("status events", 8'h04, 32'hfb3f);
		rd("status cleared", 8'h04, 32'h8b00);
		apb(1'b1, 8'h08, 32'h0110);
		pulse(10'h0c0);
		rd("checks off", 8'h04, 32'h0100);
		$display("test flags done");
		apb(1'b1, 8'h0c, 32'h0300);
		rd("clock", 8'h0c, 32'h0300);
		chk("chan enable", 32'h03, {26'h0, chanEn});
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, 8'h08, 32'h0110 | (s << 2));
			pulse(10'h021);
			cyc(4);
			chk("pin one", s == 0, readyPinOut);
			pulse(10'h002);
			cyc(4);
			chk("pin two", s >= 2, readyPinOut);
			rd("flags", 8'h04, 32'h0123);
			cyc(4);
			chk("pin idle", 32'h1, readyPinOut);
		end
		apb(1'b1, 8'h08, 32'h0115);
		pulse(10'h001);
		cyc(4);
		chk("pulse low", 32'h0, readyPinOut);
		cyc(10);
		chk("pulse over", 32'h1, readyPinOut);
		rd("flag", 8'h04, 32'h0101);
		apb(1'b1, 8'h08, 32'h0112);
		cyc(3);
		chk("float", 32'h0, readyPinOe);
		$display("test ready pin done");
		@(posedge clk) frameOn <= 1'b1;
		cyc(100);
		chk("no timeout", 32'h0, timeoutCount);
		@(posedge clk) stall <= 1'b1;
		cyc(100);
		chk("one timeout", 32'h1, timeoutCount);
		@(posedge clk) frameOn <= 1'b0;
		apb(1'b1, 8'h08, 32'h0102);
		@(posedge clk) frameOn <= 1'b1;
		cyc(100);
		chk("timeout off", 32'h1, timeoutCount);
		$display("test timeout done");
		@(posedge clk) reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd("status after reset", 8'h04, 32'h0500);
		rd("mode after reset", 8'h08, 32'h0510);
		chk("chan after reset", 32'h3f, {26'h0, chanEn});
		chk("oe after reset", 32'h1, {31'h0, readyPinOe});
		$display("test reset done");
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule

bind asm_regs asm_regs_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_asm_regs_props (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .modeOut(modeOut), .frameTimeout(frameTimeout),
	.readyPinOut(readyPinOut), .readyPinOe(readyPinOe));
